// ### core/mic_regs.svh
/*
 * register offsets, field positions, reset values and fixed figures
 * of the interrupt controller; included by its bare name.
 */
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

`define MIC_OFS_CTRL      8'h00
`define MIC_OFS_PFLAG_A   8'h04
`define MIC_OFS_PFLAG_B   8'h08
`define MIC_OFS_PEN_A     8'h0C
`define MIC_OFS_PEN_B     8'h10
`define MIC_OFS_STAT      8'h14
`define MIC_OFS_MASK      8'h18

`define MIC_CTRL_GEN      7
`define MIC_CTRL_PGE      6
`define MIC_CTRL_EN_HI    5
`define MIC_CTRL_EN_LO    3
`define MIC_CTRL_FL_HI    2
`define MIC_CTRL_FL_LO    0

`define MIC_STAT_VEC      0
`define MIC_STAT_RET      1
`define MIC_STAT_BLK      2

`define MIC_RST_CTRL      8'h00
`define MIC_RST_PREG      8'h00
`define MIC_RST_STAT      3'h0
`define MIC_VEC_ADDR      13'h0004
`define MIC_PRIME_CNT     2'h3

`endif

// ### core/mic_pkg.sv
/*
 * types shared by the interrupt controller files.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package mic_pkg;

	typedef enum logic [0:0]
	{
		MIC_ST_RUN,
		MIC_ST_SERVICE
	} mic_state_t;

endpackage

`default_nettype wire

// ### core/mic_sync.sv
/*
 * two flip-flop synchroniser for a bus of asynchronous pins.
 * assumes clk_i and a synchronous active-high rst_i.
 */
`timescale 1ns/1ps
`default_nettype none

module mic_sync
#(
	parameter int W = 1
)
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	// the first stage feeds only the second
	always_comb
	begin
		meta_d = d_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign q_o = sync_q;

endmodule // mic_sync

`default_nettype wire

// ### core/mic_top.sv
/*
 * interrupt aggregation and vectoring for an 8-bit core, with a classic
 * wishbone register slave. assumes clk_i is the instruction-cycle clock,
 * rst_i the synchronous device reset, and that the core pushes the return
 * address and loads vec_addr_o into its program counter on vector_o.
 */
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "mic_regs.svh"

module mic_top
#(
	parameter int PB_W = 4,
	parameter int PA_W = 8,
	parameter int PBW  = 4
)
(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output var  logic [31:0]     wb_dat_o,
	output var  logic            wb_ack_o,
	input  wire logic            ext_irq_pin_i,
	input  wire logic [PB_W-1:0] portb_pins_i,
	input  wire logic            timer_zero_ovf_i,
	input  wire logic [PA_W-1:0] periph_evt_a_i,
	input  wire logic [PBW-1:0]  periph_evt_b_i,
	input  wire logic            return_from_irq_i,
	output var  logic            vector_o,
	output var  logic            push_o,
	output var  logic            pc_load_o,
	output var  logic [12:0]     vec_addr_o,
	output var  logic            in_service_o,
	output var  logic            irq_o
);

	// register state
	logic [7:0]          ctrl_q;
	logic [7:0]          ctrl_d;
	logic [PA_W-1:0]     pfa_q;
	logic [PA_W-1:0]     pfa_d;
	logic [PBW-1:0]      pfb_q;
	logic [PBW-1:0]      pfb_d;
	logic [PA_W-1:0]     pea_q;
	logic [PA_W-1:0]     pea_d;
	logic [PBW-1:0]      peb_q;
	logic [PBW-1:0]      peb_d;
	logic [2:0]          stat_q;
	logic [2:0]          stat_d;
	logic [2:0]          mask_q;
	logic [2:0]          mask_d;
	logic                irq_q;
	logic                irq_d;

	// bus state
	logic                ack_q;
	logic                ack_d;
	logic [31:0]         dat_q;
	logic [31:0]         dat_d;

	// vectoring state
	mic_pkg::mic_state_t state_q;
	mic_pkg::mic_state_t state_d;
	logic                vec_q;
	logic                vec_d;
	logic [12:0]         vaddr_q;
	logic [12:0]         vaddr_d;

	// pin edge detection
	logic                ext_sync;
	logic [PB_W-1:0]     pb_sync;
	logic                ext_prev_q;
	logic                ext_prev_d;
	logic [PB_W-1:0]     pb_prev_q;
	logic [PB_W-1:0]     pb_prev_d;
	logic [1:0]          prime_q;
	logic [1:0]          prime_d;

	// combinational terms
	logic                wr_en;
	logic                ext_evt;
	logic                pb_evt;
	logic [2:0]          core_set;
	logic                periph_pend;
	logic                core_pend;
	logic                pending;
	logic                any_evt;
	logic [7:0]          wbyte;

	function automatic logic hit(input logic [7:0] adr,
		input logic [7:0] ofs);
		hit = (adr[7:2] == ofs[7:2]);
	endfunction

	// pins come from outside the clock domain
	mic_sync #(.W(1 + PB_W)) u_sync
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({ext_irq_pin_i, portb_pins_i}),
		.q_o   ({ext_sync, pb_sync})
	);

	// wishbone: write lands at the edge where ack is seen high
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];

	always_comb
	begin
		ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
		dat_d = dat_q;
		if (wb_cyc_i && wb_stb_i && !ack_q)
		begin
			dat_d = 32'h00000000;
			case (1'b1)
				hit(wb_adr_i, `MIC_OFS_CTRL):
					dat_d[7:0] = ctrl_q;
				hit(wb_adr_i, `MIC_OFS_PFLAG_A):
					dat_d[PA_W-1:0] = pfa_q;
				hit(wb_adr_i, `MIC_OFS_PFLAG_B):
					dat_d[PBW-1:0] = pfb_q;
				hit(wb_adr_i, `MIC_OFS_PEN_A):
					dat_d[PA_W-1:0] = pea_q;
				hit(wb_adr_i, `MIC_OFS_PEN_B):
					dat_d[PBW-1:0] = peb_q;
				hit(wb_adr_i, `MIC_OFS_STAT):
					dat_d[2:0] = stat_q;
				hit(wb_adr_i, `MIC_OFS_MASK):
					dat_d[2:0] = mask_q;
				default:
					dat_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	// edges are armed only once the synchroniser holds real pin levels,
	// so a pin high through reset raises no false event
	always_comb
	begin
		ext_prev_d = ext_sync;
		pb_prev_d  = pb_sync;
		prime_d    = prime_q;
		if (prime_q != `MIC_PRIME_CNT)
			prime_d = prime_q + 2'h1;
	end

	assign ext_evt = (prime_q == `MIC_PRIME_CNT) & ext_sync & ~ext_prev_q;
	assign pb_evt  = (prime_q == `MIC_PRIME_CNT) & (|(pb_sync ^ pb_prev_q));

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ext_prev_q <= 1'b0;
			pb_prev_q  <= '0;
			prime_q    <= 2'h0;
		end
		else
		begin
			ext_prev_q <= ext_prev_d;
			pb_prev_q  <= pb_prev_d;
			prime_q    <= prime_d;
		end
	end

	// flags in control bits 2:0 line up with their enables in bits 5:3
	assign core_set = {timer_zero_ovf_i, ext_evt, pb_evt};

	assign core_pend = |(ctrl_q[`MIC_CTRL_FL_HI:`MIC_CTRL_FL_LO] &
		ctrl_q[`MIC_CTRL_EN_HI:`MIC_CTRL_EN_LO]);
	assign periph_pend = ctrl_q[`MIC_CTRL_PGE] &
		((|(pfa_q & pea_q)) | (|(pfb_q & peb_q)));
	// no instruction-length input: the vector waits on nothing else
	assign pending = ctrl_q[`MIC_CTRL_GEN] &
		(core_pend | periph_pend);
	assign any_evt = (|core_set) | (|periph_evt_a_i) | (|periph_evt_b_i);

	always_comb
	begin
		ctrl_d = ctrl_q;
		pfa_d  = pfa_q;
		pfb_d  = pfb_q;
		pea_d  = pea_q;
		peb_d  = peb_q;
		if (wr_en && hit(wb_adr_i, `MIC_OFS_CTRL))
			ctrl_d[7:3] = wbyte[7:3];
		// flags set regardless of masks and enables
		// an event wins over a clear written in the same cycle
		ctrl_d[2:0] = core_set |
			(wr_en && hit(wb_adr_i, `MIC_OFS_CTRL) ? wbyte[2:0] :
			ctrl_q[2:0]);
		pfa_d = periph_evt_a_i |
			(wr_en && hit(wb_adr_i, `MIC_OFS_PFLAG_A) ? wbyte[PA_W-1:0] :
			pfa_q);
		pfb_d = periph_evt_b_i |
			(wr_en && hit(wb_adr_i, `MIC_OFS_PFLAG_B) ? wbyte[PBW-1:0] :
			pfb_q);
		if (wr_en && hit(wb_adr_i, `MIC_OFS_PEN_A))
			pea_d = wbyte[PA_W-1:0];
		if (wr_en && hit(wb_adr_i, `MIC_OFS_PEN_B))
			peb_d = wbyte[PBW-1:0];
		if (return_from_irq_i)
			ctrl_d[`MIC_CTRL_GEN] = 1'b1;
		// taking the vector wins over any set in the same cycle
		if (pending)
			ctrl_d[`MIC_CTRL_GEN] = 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= `MIC_RST_CTRL;
			pfa_q  <= PA_W'(`MIC_RST_PREG);
			pfb_q  <= PBW'(`MIC_RST_PREG);
			pea_q  <= PA_W'(`MIC_RST_PREG);
			peb_q  <= PBW'(`MIC_RST_PREG);
		end
		else
		begin
			ctrl_q <= ctrl_d;
			pfa_q  <= pfa_d;
			pfb_q  <= pfb_d;
			pea_q  <= pea_d;
			peb_q  <= peb_d;
		end
	end

	// vectoring: one pulse per accepted request; the global enable falls
	// on that edge,
	// so a flag left set cannot fire again until return or a control write sets the global enable
	always_comb
	begin
		vec_d   = pending;
		vaddr_d = `MIC_VEC_ADDR;
		state_d = state_q;
		case (state_q)
			mic_pkg::MIC_ST_RUN:
				if (pending)
					state_d = mic_pkg::MIC_ST_SERVICE;
			mic_pkg::MIC_ST_SERVICE:
				if (return_from_irq_i && !pending)
					state_d = mic_pkg::MIC_ST_RUN;
			default:
				state_d = mic_pkg::MIC_ST_RUN;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			vec_q   <= 1'b0;
			vaddr_q <= `MIC_VEC_ADDR;
			state_q <= mic_pkg::MIC_ST_RUN;
		end
		else
		begin
			vec_q   <= vec_d;
			vaddr_q <= vaddr_d;
			state_q <= state_d;
		end
	end

	// block-level interrupt: sticky status, write one to clear
	always_comb
	begin
		stat_d = stat_q;
		mask_d = mask_q;
		if (wr_en && hit(wb_adr_i, `MIC_OFS_STAT))
			stat_d = stat_q & ~wbyte[2:0];
		if (wr_en && hit(wb_adr_i, `MIC_OFS_MASK))
			mask_d = wbyte[2:0];
		if (pending)
			stat_d[`MIC_STAT_VEC] = 1'b1;
		if (return_from_irq_i)
			stat_d[`MIC_STAT_RET] = 1'b1;
		if (any_evt && !ctrl_q[`MIC_CTRL_GEN])
			stat_d[`MIC_STAT_BLK] = 1'b1;
		// from next values so irq tracks status without an extra cycle
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stat_q <= `MIC_RST_STAT;
			mask_q <= `MIC_RST_STAT;
			irq_q  <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q  <= irq_d;
		end
	end

	assign wb_ack_o     = ack_q;
	assign wb_dat_o     = dat_q;
	assign vector_o     = vec_q;
	assign push_o       = vec_q;
	assign pc_load_o    = vec_q;
	assign vec_addr_o   = vaddr_q;
	assign in_service_o = (state_q == mic_pkg::MIC_ST_SERVICE);
	assign irq_o        = irq_q;

endmodule // mic_top

`default_nettype wire

// ### test/mic_top_asserts.sv
/*
 * concurrent checks on the ports of mic_top.
 * assumes it is bound into mic_top and sees clk_i and a sync rst_i.
 */
`timescale 1ns/1ps
`default_nettype none

module mic_top_asserts
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic        wb_ack_o,
	input wire logic        return_from_irq_i,
	input wire logic        vector_o,
	input wire logic        push_o,
	input wire logic        pc_load_o,
	input wire logic [12:0] vec_addr_o,
	input wire logic        in_service_o,
	input wire logic        irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_follows_a: assert property
		(wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	vec_one_a: assert property
		(vector_o |-> push_o && pc_load_o && vec_addr_o == 13'h0004)
		else $error("vector without push or load of 0004h");
	vec_pulse_a: assert property (vector_o |=> !vector_o)
		else $error("vector taken twice in a row");
	svc_enter_a: assert property (vector_o |-> in_service_o)
		else $error("vector without service state");
	ret_exit_a: assert property
		(return_from_irq_i |=> !in_service_o)
		else $error("return did not leave service");
	reset_quiet_a: assert property
		($fell(rst_i) |-> !vector_o ##1 !vector_o)
		else $error("vector right after reset");
	// a level irq may only drop after software wrote something
	irq_sticky_a: assert property ($fell(irq_o) |->
		$past(wb_we_i) || $past(wb_we_i, 2) || $past(wb_we_i, 3))
		else $error("irq dropped without a write");
endmodule // mic_top_asserts

`default_nettype wire

// ### test/mic_core_model.sv
/*
 * behavioural core side: program counter and a nesting depth count; a return always reloads 0100h.
 * assumes vector pulses from mic_top and a return request from the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module mic_core_model
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        vector_i,
	input  wire logic        push_i,
	input  wire logic        pc_load_i,
	input  wire logic [12:0] vec_addr_i,
	input  wire logic        ret_req_i,
	output var  logic        return_from_irq_o,
	output var  logic [12:0] pc_o,
	output var  logic [3:0]  depth_o
);
	always_ff @(posedge clk_i)
	begin
		return_from_irq_o <= 1'b0;
		if (rst_i)
		begin
			pc_o    <= 13'h0100;
			depth_o <= 4'h0;
		end
		else if (vector_i && push_i && pc_load_i)
		begin
			pc_o    <= vec_addr_i;
			depth_o <= depth_o + 4'h1;
		end
		// return only from inside a routine, as the real core would
		else if (ret_req_i && depth_o != 4'h0)
		begin
			return_from_irq_o <= 1'b1;
			depth_o           <= depth_o - 4'h1;
			pc_o              <= 13'h0100;
		end
	end
endmodule // mic_core_model

`default_nettype wire

// ### test/mic_top_bench.sv
/*
 * self-checking bench for mic_top with a core model.
 * assumes default parameters: 4 port pins, 8 + 4 peripheral flags.
 */
`timescale 1ns/1ps
`default_nettype none

module mic_top_bench;
	logic        clk_i = 0, rst_i = 1, ret_req = 0;
	logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [7:0]  wb_adr_i = 0, periph_evt_a_i = 0;
	logic [3:0]  wb_sel_i = 4'hF, portb_pins_i = 0, periph_evt_b_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, q;
	logic        ext_irq_pin_i = 0, timer_zero_ovf_i = 0;
	logic        wb_ack_o, return_from_irq_i, vector_o, push_o, pc_load_o;
	logic        in_service_o, irq_o;
	logic [12:0] vec_addr_o, pc_o;
	logic [3:0]  depth_o;
	int          errors = 0, num_checks = 0, vcnt = 0, cycles = 0, n, v0;

	always #5 clk_i = ~clk_i;

	mic_top i_mic_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.ext_irq_pin_i, .portb_pins_i, .timer_zero_ovf_i, .periph_evt_a_i,
		.periph_evt_b_i, .return_from_irq_i, .vector_o, .push_o,
		.pc_load_o, .vec_addr_o, .in_service_o, .irq_o);
	mic_core_model i_mic_core_model (.clk_i, .rst_i, .vector_i(vector_o),
		.push_i(push_o), .pc_load_i(pc_load_o), .vec_addr_i(vec_addr_o),
		.ret_req_i(ret_req), .return_from_irq_o(return_from_irq_i),
		.pc_o, .depth_o);

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// classic cycle: hold everything until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		// only the bench timeout ends a wait for ack
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic svc_return;
		@(posedge clk_i);
		ret_req <= 1'b1;
		@(posedge clk_i);
		ret_req <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		vcnt <= vcnt + (vector_o === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			errors++;
			finish_test;
		end
	end

	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(8'h00, 32'h00);
		rd(8'h1C, 32'h00);
		$display("reset test done");
		{periph_evt_a_i, periph_evt_b_i, timer_zero_ovf_i} <= 13'h1FFF;
		@(posedge clk_i);
		{periph_evt_a_i, periph_evt_b_i, timer_zero_ovf_i} <= 13'h0000;
		rd(8'h04, 32'hFF);
		rd(8'h08, 32'h0F);
		rd(8'h00, 32'h04);
		chk(vcnt, 0);
		wb(1'b1, 8'h04, 32'h00);
		wb(1'b1, 8'h08, 32'h00);
		wb(1'b1, 8'h00, 32'h00);
		rd(8'h08, 32'h00);
		$display("flag test done");
		periph_evt_a_i <= 8'h08;
		@(posedge clk_i);
		periph_evt_a_i <= 8'h00;
		wb(1'b1, 8'h0C, 32'h08);
		wb(1'b1, 8'h00, 32'h80);
		repeat (4) @(posedge clk_i);
		chk(vcnt, 0);
		wb(1'b1, 8'h00, 32'hC0);
		repeat (3) @(posedge clk_i);
		chk(vcnt, 1);
		chk(pc_o, 13'h0004);
		chk(in_service_o, 1);
		rd(8'h00, 32'h40);
		rd(8'h04, 32'h08);
		wb(1'b1, 8'h04, 32'h00);
		svc_return;
		rd(8'h00, 32'hC0);
		chk(in_service_o, 0);
		chk(vcnt, 1);
		$display("group enable test done");
		for (int k = 0; k < 2; k++)
		begin
			wb(1'b1, 8'h00, k ? 32'h90 : 32'h88);
			v0 = vcnt;
			@(posedge clk_i);
			if (k)
				ext_irq_pin_i <= 1'b1;
			else
				portb_pins_i <= 4'h1;
			n = 0;
			// n counts rising edges from the pin change to the vector edge
			do begin @(posedge clk_i); n++; @(negedge clk_i); end
			while (vector_o !== 1'b1 && n < 10);
			chk(n == 3 || n == 4, 1);
			wb(1'b1, 8'h00, k ? 32'h10 : 32'h08);
			svc_return;
			rd(8'h00, k ? 32'h90 : 32'h88);
			chk(vcnt, v0 + 1);
		end
		$display("pin latency test done");
		wb(1'b1, 8'h18, 32'h00);
		repeat (2) @(negedge clk_i);
		chk(irq_o, 0);
		wb(1'b1, 8'h18, 32'h01);
		repeat (2) @(negedge clk_i);
		chk(irq_o, 1);
		wb(1'b1, 8'h14, 32'h01);
		repeat (2) @(negedge clk_i);
		chk(irq_o, 0);
		rd(8'h14, 32'h06);
		$display("status test done");
		finish_test;
	end
endmodule // mic_top_bench

bind mic_top mic_top_asserts i_mic_top_asserts (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_ack_o, .return_from_irq_i, .vector_o, .push_o,
	.pc_load_o, .vec_addr_o, .in_service_o, .irq_o);

`default_nettype wire
